/* src/alu_subset_pkg.sv */
package alu_subset_pkg;

    // Datapath and file geometry
    localparam int DATA_W     = 8;
    localparam int FILE_DEPTH = 128;
    localparam int FILE_AW    = 7;
    localparam int APB_AW     = 8;

    // Register byte offsets
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_WREG   = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_FADDR  = 8'h0C;
    localparam logic [7:0] ADDR_FDATA  = 8'h10;

    // Command word layout
    localparam int CMD_LIT_LSB   = 0;
    localparam int CMD_FADDR_LSB = 8;
    localparam int CMD_SEL_LSB   = 16;
    localparam int CMD_OP_LSB    = 24;

    // Status word layout
    localparam int STAT_C_BIT  = 0;
    localparam int STAT_DC_BIT = 1;
    localparam int STAT_Z_BIT  = 2;
    localparam int STAT_OP_LSB = 8;

    // Values after reset
    localparam logic [7:0]  W_RST      = 8'h00;
    localparam logic        FLAG_RST   = 1'b0;
    localparam logic [6:0]  FADDR_RST  = 7'h00;
    localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

    typedef enum logic [3:0] {
        nop_op            = 4'h0,
        add_immediate_op  = 4'h1,
        add_file_op       = 4'h2,
        and_immediate_op  = 4'h3,
        and_file_op       = 4'h4,
        or_immediate_op   = 4'h5,
        or_file_op        = 4'h6,
        bit_clear_op      = 4'h7,
        bit_set_op        = 4'h8,
        load_immediate_op = 4'h9,
        store_working_op  = 4'hA,
        move_file_op      = 4'hB
    } op_type;

    typedef enum logic [2:0] {
        st_idle   = 3'b000,
        st_bus_rd = 3'b001,
        st_answer = 3'b010,
        st_exec   = 3'b011
    } fsm_type;

endpackage

/* src/file_ram.sv */
`timescale 1ns/1ps
module file_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Access port
    input  wire logic             re,
    input  wire logic             we,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] rdata
);
    if (DEPTH != (1 << AW) || WIDTH < 1) begin : g_bad_geometry
        $error("file_ram: DEPTH must equal 2**AW");
    end

    logic [WIDTH-1:0] mem [DEPTH];

    // Contents are not reset; software must load what it uses
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= mem[addr];
        end
    end
endmodule

/* src/accumulator_alu_subset.sv */
//Contract
//- Add immediate: W plus 8-bit literal into W, updates carry, digit carry, zero.
//- Add file: W plus file register 0..127, updates carry, digit carry, zero.
//- File ops: select 0 sends result to W, select 1 back to file register.
//- AND file: W and file register, routed by select, only zero flag changes.
//- AND immediate: W and literal into W, only zero flag changes.
//- OR immediate: W or literal into W, only zero flag changes.
//- OR file: W or file register, to file when select 1, only zero changes.
//- Bit clear: chosen bit 0..7 of file register forced low, flags untouched.
//- Bit set: chosen bit of file register forced high, flags untouched.
//- Load immediate: literal into W, flags untouched.
//- Store working: W copied into file register, flags untouched.
//- Move file: file register to destination, zero flag updated as a test.
`timescale 1ns/1ps
module accumulator_alu_subset
    import alu_subset_pkg::*;
#(
    parameter int DEPTH = FILE_DEPTH
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr
);
    if (DEPTH != FILE_DEPTH) begin : g_bad_depth
        $error("accumulator_alu_subset: file depth must match 7-bit file address");
    end

    typedef struct packed {
        fsm_type     fsm;
        logic [7:0]  w;
        logic        c;
        logic        dc;
        logic        z;
        op_type      op;
        logic [7:0]  lit;
        logic [6:0]  faddr;
        logic [2:0]  sel;
        logic [6:0]  faddr_sw;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } state_type;

    state_type st_q;
    state_type st_d;

    logic             mem_re;
    logic             mem_we;
    logic [6:0]       mem_addr;
    logic [7:0]       mem_wdata;
    logic [7:0]       mem_rdata;
    logic             exec;
    logic             imm_op;
    logic             file_dest_op;
    logic             updates_z;
    logic [7:0]       opnd;
    logic [8:0]       sum9;
    logic [4:0]       hsum5;
    logic [7:0]       sum_lo;
    logic             carry_out;
    logic             digit_out;
    logic [7:0]       res;
    logic             res_zero;
    logic [2:0]       flags;
    logic [31:0]      rd_word;
    logic             rd_hit;

    function automatic logic [7:0] bit_mask(input logic [2:0] pos);
        bit_mask = 8'h01 << pos;
    endfunction

    file_ram #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH),
        .AW    (FILE_AW)
    ) u_file (
        .pclk    (pclk),
        .presetn (presetn),
        .re      (mem_re),
        .we      (mem_we),
        .addr    (mem_addr),
        .wdata   (mem_wdata),
        .rdata   (mem_rdata)
    );

    // Datapath; file operand is the registered read issued one cycle earlier
    assign exec   = (st_q.fsm == st_exec);
    assign imm_op = (st_q.op == add_immediate_op) || (st_q.op == and_immediate_op) ||
                    (st_q.op == or_immediate_op) || (st_q.op == load_immediate_op);
    assign file_dest_op = (st_q.op == add_file_op) || (st_q.op == and_file_op) ||
                          (st_q.op == or_file_op) || (st_q.op == move_file_op);
    assign updates_z = file_dest_op || (st_q.op == add_immediate_op) ||
                       (st_q.op == and_immediate_op) || (st_q.op == or_immediate_op);
    assign opnd      = imm_op ? st_q.lit : mem_rdata;
    assign sum9      = {1'b0, st_q.w} + {1'b0, opnd};
    assign hsum5     = {1'b0, st_q.w[3:0]} + {1'b0, opnd[3:0]};
    assign sum_lo    = sum9[7:0];
    assign carry_out = sum9[8];
    assign digit_out = hsum5[4];
    assign res_zero  = (res == 8'h00);
    assign flags     = {st_q.z, st_q.dc, st_q.c};

    always_comb begin
        case (st_q.op)
            add_immediate_op,
            add_file_op:       res = sum_lo;
            and_immediate_op,
            and_file_op:       res = st_q.w & opnd;
            or_immediate_op,
            or_file_op:        res = st_q.w | opnd;
            bit_clear_op:      res = mem_rdata & ~bit_mask(st_q.sel);
            bit_set_op:        res = mem_rdata | bit_mask(st_q.sel);
            load_immediate_op: res = st_q.lit;
            store_working_op:  res = st_q.w;
            move_file_op:      res = mem_rdata;
            default:           res = st_q.w;
        endcase
    end

    // Register read view
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (paddr)
            ADDR_CMD: begin
                rd_word[CMD_LIT_LSB +: 8]   = st_q.lit;
                rd_word[CMD_FADDR_LSB +: 7] = st_q.faddr;
                rd_word[CMD_SEL_LSB +: 3]   = st_q.sel;
                rd_word[CMD_OP_LSB +: 4]    = st_q.op;
            end
            ADDR_WREG:   rd_word[7:0] = st_q.w;
            ADDR_STATUS: begin
                rd_word[STAT_C_BIT]       = st_q.c;
                rd_word[STAT_DC_BIT]      = st_q.dc;
                rd_word[STAT_Z_BIT]       = st_q.z;
                rd_word[STAT_OP_LSB +: 4] = st_q.op;
            end
            ADDR_FADDR:  rd_word[6:0] = st_q.faddr_sw;
            ADDR_FDATA:  rd_word = 32'h0000_0000;
            default:     rd_hit = 1'b0;
        endcase
    end

    always_comb begin
        st_d         = st_q;
        st_d.pready  = 1'b0;
        st_d.pslverr = 1'b0;
        mem_re       = 1'b0;
        mem_we       = 1'b0;
        mem_addr     = st_q.faddr_sw;
        mem_wdata    = st_q.w;
        case (st_q.fsm)
            st_idle: begin
                // Taken from setup or from an access phase held during execution
                if (psel) begin
                    if (!pwrite && paddr == ADDR_FDATA) begin
                        mem_re   = 1'b1;
                        st_d.fsm = st_bus_rd;
                    end else begin
                        st_d.pready  = 1'b1;
                        st_d.pslverr = !rd_hit;
                        st_d.prdata  = (pwrite || !rd_hit) ? 32'h0000_0000 : rd_word;
                        st_d.fsm     = st_answer;
                    end
                end
            end
            st_bus_rd: begin
                st_d.prdata = {24'h000000, mem_rdata};
                st_d.pready = 1'b1;
                st_d.fsm    = st_answer;
            end
            st_answer: begin
                st_d.fsm = st_idle;
                if (psel && penable && pwrite && !st_q.pslverr) begin
                    case (paddr)
                        ADDR_CMD: begin
                            st_d.lit   = pwdata[CMD_LIT_LSB +: 8];
                            st_d.faddr = pwdata[CMD_FADDR_LSB +: 7];
                            st_d.sel   = pwdata[CMD_SEL_LSB +: 3];
                            st_d.op    = op_type'(pwdata[CMD_OP_LSB +: 4]);
                            mem_re     = 1'b1;
                            mem_addr   = pwdata[CMD_FADDR_LSB +: 7];
                            st_d.fsm   = st_exec;
                        end
                        ADDR_WREG: begin
                            if (pstrb[0]) begin
                                st_d.w = pwdata[7:0];
                            end
                        end
                        ADDR_STATUS: begin
                            if (pstrb[0]) begin
                                st_d.c  = pwdata[STAT_C_BIT];
                                st_d.dc = pwdata[STAT_DC_BIT];
                                st_d.z  = pwdata[STAT_Z_BIT];
                            end
                        end
                        ADDR_FADDR: begin
                            if (pstrb[0]) begin
                                st_d.faddr_sw = pwdata[6:0];
                            end
                        end
                        ADDR_FDATA: begin
                            mem_we    = pstrb[0];
                            mem_wdata = pwdata[7:0];
                        end
                        default: begin
                        end
                    endcase
                end
            end
            st_exec: begin
                st_d.fsm  = st_idle;
                mem_addr  = st_q.faddr;
                mem_wdata = res;
                if (imm_op) begin
                    st_d.w = res;
                end else if (file_dest_op) begin
                    if (st_q.sel[0]) begin
                        mem_we = 1'b1;
                    end else begin
                        st_d.w = res;
                    end
                end else if (st_q.op == bit_clear_op || st_q.op == bit_set_op ||
                             st_q.op == store_working_op) begin
                    mem_we = 1'b1;
                end
                if (updates_z) begin
                    st_d.z = res_zero;
                end
                if (st_q.op == add_immediate_op || st_q.op == add_file_op) begin
                    st_d.c  = carry_out;
                    st_d.dc = digit_out;
                end
            end
            default: st_d.fsm = st_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{fsm: st_idle, w: W_RST, c: FLAG_RST, dc: FLAG_RST, z: FLAG_RST,
                      op: nop_op, lit: 8'h00, faddr: FADDR_RST, sel: 3'h0,
                      faddr_sw: FADDR_RST, pready: 1'b0, pslverr: 1'b0,
                      prdata: PRDATA_RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata  = st_q.prdata;
    assign pready  = st_q.pready;
    assign pslverr = st_q.pslverr;

    // Checks on the datapath and on the error answer
    chk_add_lit_sum: assert property (@(posedge pclk) disable iff (!presetn)
        exec && st_q.op == add_immediate_op |=>
            st_q.w == $past(sum_lo) && st_q.z == ($past(sum_lo) == 8'h00))
        else $error("add immediate result wrong");

    chk_add_file_w: assert property (@(posedge pclk) disable iff (!presetn)
        exec && st_q.op == add_file_op && !st_q.sel[0] |=>
            st_q.w == $past(sum_lo) && st_q.c == $past(carry_out))
        else $error("add file result wrong");

    chk_dest_file: assert property (@(posedge pclk) disable iff (!presetn)
        exec && file_dest_op && st_q.sel[0] |->
            mem_we && mem_addr == st_q.faddr && mem_wdata == res ##1 $stable(st_q.w))
        else $error("file destination not written");

    chk_dest_work: assert property (@(posedge pclk) disable iff (!presetn)
        exec && file_dest_op && !st_q.sel[0] |-> !mem_we ##1 st_q.w == $past(res))
        else $error("working destination not written");

    chk_and_file_flags: assert property (@(posedge pclk) disable iff (!presetn)
        exec && st_q.op == and_file_op |=> $stable(st_q.c) && $stable(st_q.dc))
        else $error("and file touched carry flags");

    chk_and_lit_w: assert property (@(posedge pclk) disable iff (!presetn)
        exec && st_q.op == and_immediate_op |=>
            st_q.w == ($past(st_q.w) & $past(st_q.lit)) && $stable(st_q.c))
        else $error("and immediate wrong");

    chk_or_lit_w: assert property (@(posedge pclk) disable iff (!presetn)
        exec && st_q.op == or_immediate_op |=>
            st_q.w == ($past(st_q.w) | $past(st_q.lit)) && $stable(st_q.dc))
        else $error("or immediate wrong");

    chk_or_file_back: assert property (@(posedge pclk) disable iff (!presetn)
        exec && st_q.op == or_file_op && st_q.sel[0] |->
            mem_we && mem_wdata == (st_q.w | mem_rdata))
        else $error("or file write back wrong");

    chk_bit_clear: assert property (@(posedge pclk) disable iff (!presetn)
        exec && st_q.op == bit_clear_op |->
            mem_we && !mem_wdata[st_q.sel] ##1 $stable(flags))
        else $error("bit clear wrong");

    chk_bit_set: assert property (@(posedge pclk) disable iff (!presetn)
        exec && st_q.op == bit_set_op |->
            mem_we && mem_wdata == (mem_rdata | bit_mask(st_q.sel)) ##1 $stable(flags))
        else $error("bit set wrong");

    chk_load_imm: assert property (@(posedge pclk) disable iff (!presetn)
        exec && st_q.op == load_immediate_op |=>
            st_q.w == $past(st_q.lit) && $stable(flags))
        else $error("load immediate wrong");

    chk_store_work: assert property (@(posedge pclk) disable iff (!presetn)
        exec && st_q.op == store_working_op |->
            mem_we && mem_wdata == st_q.w ##1 $stable(flags))
        else $error("store working wrong");

    chk_move_test: assert property (@(posedge pclk) disable iff (!presetn)
        exec && st_q.op == move_file_op && st_q.sel[0] |->
            mem_we && mem_wdata == mem_rdata ##1 st_q.z == ($past(mem_rdata) == 8'h00))
        else $error("move file test wrong");

    chk_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
        exec && updates_z |=> st_q.z == ($past(res) == 8'h00))
        else $error("zero flag wrong");

    chk_digit_carry: assert property (@(posedge pclk) disable iff (!presetn)
        exec && (st_q.op == add_immediate_op || st_q.op == add_file_op) |=>
            st_q.dc == $past(digit_out) && st_q.c == $past(carry_out))
        else $error("carry flags wrong");

    chk_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr |-> prdata == 32'h0000_0000 ##1 !pready)
        else $error("error answer malformed");
endmodule

/* sim/apb_decoder_model.sv */
`timescale 1ns/1ps
module apb_decoder_model (
    // Clock
    input  wire logic        pclk,
    // Request to the datapath
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    // Answer from the datapath
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
    end

    // Request held until pready is seen at a rising edge; answer taken at that edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import alu_subset_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    int          error_cnt;
    int          comparisons;
    int          cycles;
    logic [31:0] q;
    logic        e;

    accumulator_alu_subset #(.DEPTH(FILE_DEPTH)) accumulator_alu_subset_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr)
    );

    apb_decoder_model apb_decoder_model_inst (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic conclude();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        er;
        apb_decoder_model_inst.xfer(1'b1, a, d, 4'hF, r, er);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic er);
        apb_decoder_model_inst.xfer(1'b0, a, 32'h0000_0000, 4'hF, r, er);
    endtask

    // Loads file, W and flags, executes one command, then checks W, flags and file
    task automatic run(input op_type op, input logic [7:0] lit, input logic [6:0] fa,
                       input logic [2:0] sel, input logic [7:0] fv, input logic [7:0] wv,
                       input logic [2:0] ps);
        logic [8:0]  s;
        logic [4:0]  s4;
        logic [7:0]  b;
        logic [7:0]  r;
        logic [7:0]  wn;
        logic [7:0]  fn;
        logic        c;
        logic        dc;
        logic        z;
        logic [31:0] v;
        logic        er;
        wr(ADDR_FADDR, {25'h0, fa});
        wr(ADDR_FDATA, {24'h0, fv});
        wr(ADDR_WREG, {24'h0, wv});
        wr(ADDR_STATUS, {29'h0, ps});
        wr(ADDR_CMD, {4'h0, op, 5'h00, sel, 1'b0, fa, lit});
        {z, dc, c} = ps;
        wn = wv;
        fn = fv;
        b = (op inside {add_file_op, and_file_op, or_file_op}) ? fv : lit;
        s = {1'b0, wv} + {1'b0, b};
        s4 = {1'b0, wv[3:0]} + {1'b0, b[3:0]};
        case (op)
            add_immediate_op, add_file_op: begin
                r = s[7:0];
                c = s[8];
                dc = s4[4];
            end
            and_immediate_op, and_file_op: r = wv & b;
            or_immediate_op, or_file_op: r = wv | b;
            default: r = fv;
        endcase
        if (!(op inside {bit_clear_op, bit_set_op, load_immediate_op, store_working_op}))
            z = (r == 8'h00);
        case (op)
            add_immediate_op, and_immediate_op, or_immediate_op: wn = r;
            bit_clear_op: fn[sel] = 1'b0;
            bit_set_op: fn[sel] = 1'b1;
            load_immediate_op: wn = lit;
            store_working_op: fn = wv;
            default: if (sel[0]) fn = r; else wn = r;
        endcase
        rd(ADDR_WREG, v, er);
        chk(v, {24'h0, wn});
        rd(ADDR_STATUS, v, er);
        chk({20'h0, v[11:8], 5'h00, v[2:0]}, {20'h0, op, 5'h00, z, dc, c});
        rd(ADDR_FDATA, v, er);
        chk(v, {24'h0, fn});
    endtask

    initial begin
        error_cnt = 0;
        comparisons = 0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_WREG, q, e);
        chk(q, {24'h0, W_RST});
        rd(ADDR_STATUS, q, e);
        chk(q, 32'h0000_0000);
        rd(8'h14, q, e);
        chk(q, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        // Strobe low on byte 0 must leave W alone
        apb_decoder_model_inst.xfer(1'b1, ADDR_WREG, 32'h0000_00FF, 4'h0, q, e);
        rd(ADDR_WREG, q, e);
        chk(q, {24'h0, W_RST});
        // Unmapped write must not alias onto the command register
        wr(8'h40, 32'h0000_00FF);
        rd(ADDR_CMD, q, e);
        chk(q, 32'h0000_0000);
        run(add_immediate_op, 8'h01, 7'h05, 3'h0, 8'h00, 8'hFF, 3'h0);
        run(add_immediate_op, 8'h01, 7'h05, 3'h0, 8'h00, 8'h0F, 3'h7);
        run(add_file_op, 8'h00, 7'h7F, 3'h1, 8'h80, 8'h80, 3'h0);
        run(add_file_op, 8'h00, 7'h00, 3'h0, 8'h12, 8'h34, 3'h7);
        run(and_file_op, 8'h00, 7'h11, 3'h0, 8'h3C, 8'h0F, 3'h3);
        run(and_file_op, 8'h00, 7'h12, 3'h1, 8'hF0, 8'h0F, 3'h0);
        run(and_immediate_op, 8'h0F, 7'h13, 3'h0, 8'h00, 8'hF0, 3'h3);
        run(and_immediate_op, 8'hFF, 7'h13, 3'h0, 8'h00, 8'hA5, 3'h4);
        run(or_immediate_op, 8'h00, 7'h14, 3'h0, 8'h00, 8'h00, 3'h3);
        run(or_immediate_op, 8'h81, 7'h14, 3'h0, 8'h00, 8'h18, 3'h4);
        run(or_file_op, 8'h00, 7'h7F, 3'h1, 8'h50, 8'h05, 3'h7);
        run(or_file_op, 8'h00, 7'h15, 3'h0, 8'h00, 8'h00, 3'h0);
        run(bit_clear_op, 8'h00, 7'h7F, 3'h7, 8'hFF, 8'h00, 3'h7);
        run(bit_clear_op, 8'h00, 7'h20, 3'h0, 8'h01, 8'h00, 3'h0);
        run(bit_set_op, 8'h00, 7'h21, 3'h7, 8'h00, 8'h00, 3'h0);
        run(bit_set_op, 8'h00, 7'h22, 3'h2, 8'h00, 8'h11, 3'h7);
        run(load_immediate_op, 8'h00, 7'h23, 3'h0, 8'h33, 8'hAA, 3'h3);
        run(load_immediate_op, 8'hFF, 7'h23, 3'h1, 8'h33, 8'h00, 3'h4);
        run(store_working_op, 8'h00, 7'h7F, 3'h0, 8'h5A, 8'hA5, 3'h7);
        run(move_file_op, 8'h00, 7'h30, 3'h1, 8'h00, 8'h77, 3'h0);
        run(move_file_op, 8'h00, 7'h31, 3'h0, 8'h80, 8'h00, 3'h7);
        conclude();
    end
endmodule
